// File: hdl/bsc_pkg.sv
// Constants, field layouts and carrier types of the bridge split-control and sticky error-status registers.
// Assumes configuration cycles arrive already decoded to one dword offset and one bridge function.

`default_nettype none

package bsc_pkg;

  // Register offsets, as byte addresses in configuration space.
  localparam logic [7:0] OFS_SPLIT_CTL = 8'h5c;
  localparam logic [7:0] OFS_ERR_STS = 8'h60;

  // Split control layout and reset values.
  localparam logic [31:0] SPLIT_CTL_RESET = 32'h0000ffff;
  localparam logic [15:0] SPLIT_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] SPLIT_CAPACITY = 16'hffff;
  localparam int POS_SPLIT_LIMIT = 16;

  // Error status field positions.
  localparam int POS_BUS_AGENT = 21;
  localparam int POS_HUB_AGENT = 20;
  localparam int POS_RSVD_LO = 16;
  localparam int POS_NF_ENABLE = 15;
  localparam int POS_PAR_NF = 14;
  localparam int POS_HUB_TA = 13;
  localparam int POS_NF_LO = 8;
  localparam int POS_BUS_APAR = 0;
  localparam int POS_BUS_DPAR = 2;

  // Bus agent codes with a fixed meaning.
  localparam logic [2:0] AGENT_RESERVED = 3'h6;
  localparam logic [2:0] AGENT_BRIDGE = 3'h7;

  // Function numbering inside this block.
  localparam int FN_DEV29 = 0;
  localparam int FN_DEV31 = 1;
  localparam int NUM_FN = 2;

  // One configuration cycle, offered for one clock.
  typedef struct packed {
    logic wr;
    logic rd;
    logic dev31;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bsc_cfg_req_type;

  // Error events and lower status bits of one bridge function.
  typedef struct packed {
    logic [12:0] low_status;
    logic buf_fatal;
    logic bus_fail_evt;
    logic [2:0] bus_agent;
    logic hub_fail_evt;
    logic hub_agent;
    logic hub_ta;
  } bsc_err_evt_type;

endpackage : bsc_pkg

`default_nettype wire

// File: hdl/bsc_ras_status.sv
// Sticky error status register of one bridge function.
// Assumes writes arrive as one-cycle strobes with byte enables and that bits 12:0 are kept elsewhere.

`default_nettype none

module bsc_ras_status #(
  parameter bit HUB_VISIBLE = 1'b0
) (
  // Clock and reset; reset only qualifies checks, the state is sticky.
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Register write port.
  input wire logic wr_i,
  input wire logic [2:0] be_i,
  input wire logic [23:0] wdata_i,
  // Error events.
  input wire bsc_pkg::bsc_err_evt_type evt_i,
  // Register contents.
  output logic [23:0] status_o
);

  logic [2:0] bus_agent_ff;
  logic [2:0] nxt_bus_agent_ff;
  logic hub_agent_ff;
  logic nxt_hub_agent_ff;
  logic nf_enable_ff;
  logic nxt_nf_enable_ff;
  logic par_nf_ff;
  logic nxt_par_nf_ff;
  logic hub_ta_ff;
  logic nxt_hub_ta_ff;
  logic wr_hi;

  assign wr_hi = wr_i & be_i[1];

  logic ran_ff;
  logic nxt_ran_ff;

  // Set once reset has been released; the power-on contents are unknown, so the sticky check waits for this.
  always_comb begin
    nxt_ran_ff = ran_ff | reset_n_i;
  end

  always_ff @(posedge ref_clk_i) begin
    ran_ff <= nxt_ran_ff;
  end

  // Next values; a new bus event, or a hub event when HUB_VISIBLE is set, overrides an older capture so the field names the latest failure.
  always_comb begin
    nxt_bus_agent_ff = bus_agent_ff;
    nxt_hub_agent_ff = hub_agent_ff;
    nxt_nf_enable_ff = nf_enable_ff;
    nxt_par_nf_ff = par_nf_ff;
    if (evt_i.bus_fail_evt) begin
      nxt_bus_agent_ff = evt_i.bus_agent;
    end
    if (HUB_VISIBLE && evt_i.hub_fail_evt) begin
      nxt_hub_agent_ff = evt_i.hub_agent;
    end
    if (wr_hi) begin
      nxt_nf_enable_ff = wdata_i[bsc_pkg::POS_NF_ENABLE];
      nxt_par_nf_ff = wdata_i[bsc_pkg::POS_PAR_NF];
    end
    // The set wins over a clear in the same cycle so no abort is lost.
    nxt_hub_ta_ff = (HUB_VISIBLE & evt_i.hub_ta) |
                    (hub_ta_ff & ~(wr_hi & wdata_i[bsc_pkg::POS_HUB_TA]));
  end

  // No reset branch: logged errors must survive a reset of the bridge.
  always_ff @(posedge ref_clk_i) begin
    bus_agent_ff <= nxt_bus_agent_ff;
    hub_agent_ff <= nxt_hub_agent_ff;
    nf_enable_ff <= nxt_nf_enable_ff;
    par_nf_ff <= nxt_par_nf_ff;
    hub_ta_ff <= nxt_hub_ta_ff;
  end

  // Hub fields read as zero outside the device-31 function; reserved bits always read zero.
  assign status_o = {bus_agent_ff, hub_agent_ff & HUB_VISIBLE, 4'h0, nf_enable_ff, par_nf_ff,
                     hub_ta_ff & HUB_VISIBLE, evt_i.low_status};

  chk_sticky_reset: assert property (@(posedge ref_clk_i) ran_ff && !reset_n_i && !wr_i && !evt_i.bus_fail_evt
    && !evt_i.hub_fail_evt && !evt_i.hub_ta |=> status_o[23:13] == $past(status_o[23:13]))
    else $error("status changed during reset");
  chk_hta_set: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    HUB_VISIBLE && evt_i.hub_ta |=> status_o[bsc_pkg::POS_HUB_TA])
    else $error("hub target abort not logged");
  chk_hta_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    hub_ta_ff && !(wr_hi && wdata_i[bsc_pkg::POS_HUB_TA]) |=> hub_ta_ff)
    else $error("hub target abort cleared without a one write");
  chk_bus_agent: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    evt_i.bus_fail_evt |=> status_o[23:21] == $past(evt_i.bus_agent))
    else $error("bus agent not captured");

endmodule : bsc_ras_status

`default_nettype wire

// File: hdl/bsc_ctl.sv
// Split-control and sticky error-status configuration registers of both bridge functions, with the error pin.
// Assumes configuration cycles come one at a time, decoded to a dword offset and a function select.

`default_nettype none

module bsc_ctl (
  // Clock and synchronous reset.
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Configuration access.
  input wire bsc_pkg::bsc_cfg_req_type cfg_req_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  // Error events of each function.
  input wire bsc_pkg::bsc_err_evt_type evt_dev29_i,
  input wire bsc_pkg::bsc_err_evt_type evt_dev31_i,
  // Error signalling and hub-side class.
  output logic error_output_pin_n_o,
  output logic hub_parity_nonfatal_o,
  // Stored split limits, for diagnostics only.
  output logic [15:0] split_limit_dev29_o,
  output logic [15:0] split_limit_dev31_o
);

  bsc_pkg::bsc_err_evt_type evt [bsc_pkg::NUM_FN];
  logic [bsc_pkg::NUM_FN-1:0][23:0] sts;
  logic [bsc_pkg::NUM_FN-1:0][15:0] split_limit_ff;
  logic [bsc_pkg::NUM_FN-1:0] fatal;
  logic [bsc_pkg::NUM_FN-1:0] nonfatal;
  logic hit_split;
  logic hit_sts;
  logic ack_ff;
  logic nxt_ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata_ff;
  logic err_ff;
  logic nxt_err_ff;
  logic [bsc_pkg::NUM_FN-1:0][15:0] nxt_split_limit_ff;

  assign evt[bsc_pkg::FN_DEV29] = evt_dev29_i;
  assign evt[bsc_pkg::FN_DEV31] = evt_dev31_i;

  // Offset decode, shared by both functions.
  assign hit_split = cfg_req_i.dw_addr == bsc_pkg::OFS_SPLIT_CTL[7:2];
  assign hit_sts = cfg_req_i.dw_addr == bsc_pkg::OFS_ERR_STS[7:2];

  // Per-function registers and error classification.
  for (genvar g = 0; g < bsc_pkg::NUM_FN; g++) begin : g_fn
    logic fn_sel;
    logic par_nf;
    logic bus_par;

    assign fn_sel = cfg_req_i.dev31 == (g == bsc_pkg::FN_DEV31);

    // Limit bytes follow the byte enables; the stored value steers nothing in the buffers.
    always_comb begin
      nxt_split_limit_ff[g] = split_limit_ff[g];
      if (cfg_req_i.wr && fn_sel && hit_split) begin
        if (cfg_req_i.be[2]) begin
          nxt_split_limit_ff[g][7:0] = cfg_req_i.wdata[23:16];
        end
        if (cfg_req_i.be[3]) begin
          nxt_split_limit_ff[g][15:8] = cfg_req_i.wdata[31:24];
        end
      end
    end

    always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
        split_limit_ff[g] <= bsc_pkg::SPLIT_LIMIT_RESET;
      end else begin
        split_limit_ff[g] <= nxt_split_limit_ff[g];
      end
    end

    bsc_ras_status #(
      .HUB_VISIBLE(g == bsc_pkg::FN_DEV31)
    ) u_status (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .wr_i(cfg_req_i.wr && fn_sel && hit_sts),
      .be_i(cfg_req_i.be[2:0]),
      .wdata_i(cfg_req_i.wdata[23:0]),
      .evt_i(evt[g]),
      .status_o(sts[g])
    );

    // Each function classifies its own bus parity errors with its own class bit.
    assign par_nf = sts[g][bsc_pkg::POS_PAR_NF];
    assign bus_par = sts[g][bsc_pkg::POS_BUS_APAR] | sts[g][bsc_pkg::POS_BUS_DPAR];
    assign fatal[g] = (~par_nf & bus_par) | evt[g].buf_fatal;
    assign nonfatal[g] = sts[g][bsc_pkg::POS_NF_ENABLE] &
                         ((|sts[g][bsc_pkg::POS_HUB_TA:bsc_pkg::POS_NF_LO]) | (par_nf & bus_par));
  end

  // Hub-side logic listens to the device-31 copy only; a mismatched device-29 copy is ignored.
  assign hub_parity_nonfatal_o = sts[bsc_pkg::FN_DEV31][bsc_pkg::POS_PAR_NF];

  // Read data: the capacity half is a constant, and the top byte of the status register reads zero.
  always_comb begin
    nxt_ack_ff = cfg_req_i.wr | cfg_req_i.rd;
    nxt_rdata_ff = rdata_ff;
    if (cfg_req_i.rd) begin
      nxt_rdata_ff = 32'h00000000;
      if (hit_split) begin
        nxt_rdata_ff = {split_limit_ff[cfg_req_i.dev31], bsc_pkg::SPLIT_CAPACITY};
      end else if (hit_sts) begin
        nxt_rdata_ff = {8'h00, sts[cfg_req_i.dev31]};
      end
    end
  end

  // Answer one cycle after the request; unmapped offsets read zero and drop writes.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack_ff;
      rdata_ff <= nxt_rdata_ff;
    end
  end

  // The pin is a registered level so a glitch on the status decode never reaches the board.
  always_comb begin
    nxt_err_ff = |(fatal | nonfatal);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= nxt_err_ff;
    end
  end

  assign cfg_ack_o = ack_ff;
  assign cfg_rdata_o = rdata_ff;
  assign error_output_pin_n_o = ~err_ff;
  assign split_limit_dev29_o = split_limit_ff[bsc_pkg::FN_DEV29];
  assign split_limit_dev31_o = split_limit_ff[bsc_pkg::FN_DEV31];

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic rd_sts31;
  logic rd_sts29;
  logic rd_split;
  assign rd_sts31 = cfg_req_i.rd && cfg_req_i.dev31 && hit_sts;
  assign rd_sts29 = cfg_req_i.rd && !cfg_req_i.dev31 && hit_sts;
  assign rd_split = cfg_req_i.rd && hit_split;

  chk_limit_write: assert property (cfg_req_i.wr && cfg_req_i.dev31 && hit_split
    && cfg_req_i.be[3:2] == 2'h3 |=> split_limit_dev31_o == $past(cfg_req_i.wdata[31:16]))
    else $error("split limit not stored");
  chk_capacity_read: assert property (rd_split |=> cfg_ack_o && cfg_rdata_o[15:0] == 16'hffff)
    else $error("split capacity not all ones");
  chk_agent_read: assert property (rd_sts31 |=>
    cfg_rdata_o[23:20] == $past(sts[bsc_pkg::FN_DEV31][23:20]))
    else $error("failing agent fields misread");
  chk_dev29_hidden: assert property (rd_sts29 |=> cfg_rdata_o[20] == 1'b0 && cfg_rdata_o[13] == 1'b0)
    else $error("hub field visible in device 29");
  chk_reserved_zero: assert property (cfg_req_i.rd && hit_sts |=>
    cfg_rdata_o[19:16] == 4'h0 && cfg_rdata_o[31:24] == 8'h00)
    else $error("reserved status bits not zero");
  chk_nonfatal_pin: assert property (sts[bsc_pkg::FN_DEV31][bsc_pkg::POS_NF_ENABLE]
    && sts[bsc_pkg::FN_DEV31][bsc_pkg::POS_HUB_TA] |=> !error_output_pin_n_o)
    else $error("enabled non-fatal error not signalled");
  chk_nonfatal_quiet: assert property (fatal == 2'b00 && !sts[0][bsc_pkg::POS_NF_ENABLE]
    && !sts[1][bsc_pkg::POS_NF_ENABLE] |=> error_output_pin_n_o)
    else $error("error pin driven while non-fatal signalling disabled");
  chk_parity_fatal: assert property (!sts[1][bsc_pkg::POS_PAR_NF]
    && sts[1][bsc_pkg::POS_BUS_DPAR] |=> !error_output_pin_n_o)
    else $error("fatal data parity not signalled");
  chk_buffer_fatal: assert property (evt_dev29_i.buf_fatal |=> !error_output_pin_n_o)
    else $error("buffer parity error not fatal");
  chk_hub_class: assert property (cfg_req_i.wr && !cfg_req_i.dev31 && hit_sts
    |=> hub_parity_nonfatal_o == $past(hub_parity_nonfatal_o))
    else $error("hub class followed device 29");

  cov_limit_write: cover property (cfg_req_i.wr && hit_split ##1 rd_split);
  cov_hta_clear: cover property (sts[1][bsc_pkg::POS_HUB_TA] ##1 !sts[1][bsc_pkg::POS_HUB_TA]);
  cov_nonfatal_err: cover property (nonfatal[1] && fatal == 2'b00 ##1 !error_output_pin_n_o);
  cov_bridge_agent: cover property (rd_sts31 ##1 cfg_rdata_o[23:21] == bsc_pkg::AGENT_BRIDGE);

endmodule : bsc_ctl

`default_nettype wire

// File: bench/bsc_err_src.sv
// Error event source standing in for the bus, buffer and hub-side error logic of both functions.
// Assumes the bench calls its tasks one at a time; levels change and pulses last one cycle from a falling edge.

`default_nettype none

module bsc_err_src (
  // Clock of the event logic.
  input wire logic ref_clk_i,
  // Events towards each function.
  output var bsc_pkg::bsc_err_evt_type evt_dev29_o,
  output var bsc_pkg::bsc_err_evt_type evt_dev31_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Start with no error so that software can clear the log first.
  initial begin
    evt_dev29_o = '0;
    evt_dev31_o = '0;
  end

  // One bus failure; the agent lines are inverted afterwards so a late sample cannot pass by luck.
  task automatic bus_fail(input bit fn, input logic [2:0] agent);
    @(negedge ref_clk_i);
    if (fn) evt_dev31_o.bus_fail_evt = 1'b1;
    else evt_dev29_o.bus_fail_evt = 1'b1;
    evt_dev29_o.bus_agent = agent;
    evt_dev31_o.bus_agent = agent;
    @(negedge ref_clk_i);
    evt_dev29_o.bus_fail_evt = 1'b0;
    evt_dev31_o.bus_fail_evt = 1'b0;
    evt_dev29_o.bus_agent = ~agent;
    evt_dev31_o.bus_agent = ~agent;
  endtask : bus_fail

  // Hub failures and aborts only ever come through the device-31 function.
  task automatic hub_evt(input bit ta, input logic agent);
    @(negedge ref_clk_i);
    evt_dev31_o.hub_ta = ta;
    evt_dev31_o.hub_fail_evt = ~ta;
    evt_dev31_o.hub_agent = agent;
    @(negedge ref_clk_i);
    evt_dev31_o.hub_ta = 1'b0;
    evt_dev31_o.hub_fail_evt = 1'b0;
    evt_dev31_o.hub_agent = ~agent;
  endtask : hub_evt

  // Level inputs: lower status bits and the buffer parity error.
  task automatic set_level(input bit fn, input logic [12:0] low, input logic buf_err);
    @(negedge ref_clk_i);
    if (fn) begin
      evt_dev31_o.low_status = low;
      evt_dev31_o.buf_fatal = buf_err;
    end else begin
      evt_dev29_o.low_status = low;
      evt_dev29_o.buf_fatal = buf_err;
    end
  endtask : set_level

endmodule : bsc_err_src

`default_nettype wire

// File: bench/bsc_ctl_tb.sv
// Self-checking bench for the split-control and sticky error-status registers.
// Assumes the config port answers one cycle after each strobe and the pin is registered.

`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module bsc_ctl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  bsc_pkg::bsc_cfg_req_type cfg_req = '0;
  bsc_pkg::bsc_err_evt_type evt29;
  bsc_pkg::bsc_err_evt_type evt31;
  logic cfg_ack;
  logic [31:0] cfg_rdata;
  logic pin_n;
  logic hub_nf;
  logic [15:0] lim31;
  logic [15:0] lim29;
  int error_cnt = 0;
  int samples_checked = 0;

  // Free-running 125 MHz clock.
  always #4 ref_clk_i = ~ref_clk_i;

  bsc_err_src bsc_err_src_inst (.ref_clk_i(ref_clk_i), .evt_dev29_o(evt29), .evt_dev31_o(evt31));

  bsc_ctl bsc_ctl_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cfg_req_i(cfg_req), .cfg_ack_o(cfg_ack),
    .cfg_rdata_o(cfg_rdata), .evt_dev29_i(evt29), .evt_dev31_i(evt31), .error_output_pin_n_o(pin_n),
    .hub_parity_nonfatal_o(hub_nf), .split_limit_dev29_o(lim29), .split_limit_dev31_o(lim31));

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // One config cycle: strobe for one cycle, then wait a bounded time for the acknowledge.
  task automatic cfg(input logic wr, input logic dev31, input logic [7:0] ofs, input logic [3:0] be,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    int n;
    @(negedge ref_clk_i);
    cfg_req <= '{wr: wr, rd: ~wr, dev31: dev31, dw_addr: ofs[7:2], be: be, wdata: wdata};
    @(negedge ref_clk_i);
    cfg_req.wr <= 1'b0;
    cfg_req.rd <= 1'b0;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 4) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (cfg_ack !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: no acknowledge", $time);
      close_out();
    end else begin
      rdata = cfg_rdata;
    end
  endtask : cfg

  task automatic wr_reg(input logic dev31, input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] unused;
    cfg(1'b1, dev31, ofs, be, d, unused);
  endtask : wr_reg

  task automatic rd_chk(input logic dev31, input logic [7:0] ofs, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    cfg(1'b0, dev31, ofs, 4'hf, 32'h0, r);
    `CHK(r & mask, exp)
  endtask : rd_chk

  // The pin is registered, so give the cause two edges to show.
  task automatic pin_chk(input logic exp);
    repeat (2) @(negedge ref_clk_i);
    `CHK(pin_n, exp)
  endtask : pin_chk

  // Limit is stored, capacity is fixed at all ones, unmapped reads give zero.
  task automatic t_split();
    rd_chk(1'b0, 8'h5c, 32'hffffffff, 32'h0000ffff);
    wr_reg(1'b1, 8'h5c, 4'hf, 32'h5a3c0000);
    rd_chk(1'b1, 8'h5c, 32'hffffffff, 32'h5a3cffff);
    `CHK(lim31, 16'h5a3c)
    rd_chk(1'b0, 8'h5c, 32'hffffffff, 32'h0000ffff);
    wr_reg(1'b0, 8'h5c, 4'h5, 32'h12a5ffff);
    `CHK(lim29, 16'h00a5)
    rd_chk(1'b0, 8'h5c, 32'hffffffff, 32'h00a5ffff);
    rd_chk(1'b1, 8'h40, 32'hffffffff, 32'h0);
  endtask : t_split

  // Power-on clean-up of both functions; reserved bits ignore writes.
  task automatic t_init();
    // The agent fields are read-only and unknown at power-on, so log one failure of each kind first.
    bsc_err_src_inst.bus_fail(1'b1, 3'h7);
    bsc_err_src_inst.hub_evt(1'b0, 1'b0);
    // Device 31 first, so the hub-side class bit is known before device 29 is written.
    for (int f = 1; f >= 0; f--) begin
      wr_reg(f[0], 8'h60, 4'h2, 32'h00002000);
      wr_reg(f[0], 8'h60, 4'h4, 32'h000f0000);
      rd_chk(f[0], 8'h60, 32'h000fe000, 32'h0);
    end
    pin_chk(1'b1);
  endtask : t_init

  // Target abort is logged with signalling off, signals once enabled, and clears only on a one.
  task automatic t_hub_ta();
    bsc_err_src_inst.hub_evt(1'b1, 1'b0);
    rd_chk(1'b1, 8'h60, 32'h00002000, 32'h00002000);
    rd_chk(1'b0, 8'h60, 32'h00002000, 32'h0);
    pin_chk(1'b1);
    wr_reg(1'b1, 8'h60, 4'h2, 32'h00008000);
    pin_chk(1'b0);
    rd_chk(1'b1, 8'h60, 32'h00002000, 32'h00002000);
    wr_reg(1'b1, 8'h60, 4'h2, 32'h0000a000);
    rd_chk(1'b1, 8'h60, 32'h00002000, 32'h0);
    pin_chk(1'b1);
  endtask : t_hub_ta

  // Bus data parity is fatal by default, gated once non-fatal; buffer parity is always fatal.
  task automatic t_parity();
    bsc_err_src_inst.set_level(1'b0, 13'h0004, 1'b0);
    pin_chk(1'b0);
    wr_reg(1'b0, 8'h60, 4'h2, 32'h00004000);
    pin_chk(1'b1);
    `CHK(hub_nf, 1'b0)
    wr_reg(1'b0, 8'h60, 4'h2, 32'h0000c000);
    pin_chk(1'b0);
    wr_reg(1'b0, 8'h60, 4'h2, 32'h00004000);
    bsc_err_src_inst.set_level(1'b0, 13'h0000, 1'b1);
    pin_chk(1'b0);
    bsc_err_src_inst.set_level(1'b0, 13'h0000, 1'b0);
    pin_chk(1'b1);
    bsc_err_src_inst.set_level(1'b1, 13'h0004, 1'b0);
    pin_chk(1'b0);
    bsc_err_src_inst.set_level(1'b1, 13'h0000, 1'b0);
    pin_chk(1'b1);
    wr_reg(1'b1, 8'h60, 4'h2, 32'h0000c000);
    `CHK(hub_nf, 1'b1)
  endtask : t_parity

  // Every bus agent code is captured; the hub agent shows only in device 31.
  task automatic t_agent();
    for (int a = 0; a < 8; a++) begin
      bsc_err_src_inst.bus_fail(a[0], a[2:0]);
      rd_chk(a[0], 8'h60, 32'h00e00000, 32'(a) << 21);
    end
    bsc_err_src_inst.hub_evt(1'b0, 1'b1);
    rd_chk(1'b1, 8'h60, 32'h00100000, 32'h00100000);
    rd_chk(1'b0, 8'h60, 32'h00100000, 32'h0);
    bsc_err_src_inst.hub_evt(1'b0, 1'b0);
    rd_chk(1'b1, 8'h60, 32'h00100000, 32'h0);
  endtask : t_agent

  // A mid-run reset keeps the status log but restores the split limit.
  task automatic t_sticky();
    @(negedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    reset_n_i <= 1'b1;
    rd_chk(1'b1, 8'h60, 32'h00ffe000, 32'h00e0c000);
    rd_chk(1'b1, 8'h5c, 32'hffffffff, 32'h0000ffff);
    `CHK(lim29, 16'h0000)
  endtask : t_sticky

  // Main sequence.
  initial begin
    repeat (6) @(negedge ref_clk_i);
    reset_n_i <= 1'b1;
    t_split();
    t_init();
    t_hub_ta();
    t_parity();
    t_agent();
    t_sticky();
    close_out();
  end

endmodule : bsc_ctl_tb

`default_nettype wire
